// file: src/ecc_capture_compare.v
/*
 * encoder capture/compare block: filtered quadrature counter, trigger
 * capture, shutdown detection, position compare output, wishbone slave.
 * assumes a single 125 mhz clock and asynchronous pin inputs.
 */
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "ecc_defs.vh"

module ecc_capture_compare #(
    parameter FILT_W = 8,
    parameter BUF_DEPTH = 4,
    parameter BUF_AW = 2
) (
    input wire MCLK_IN,
    input wire RST_IN,
    input wire WB_CYC_IN,
    input wire WB_STB_IN,
    input wire WB_WE_IN,
    input wire [`ECC_ADDR_W-1:0] WB_ADR_IN,
    input wire [3:0] WB_SEL_IN,
    input wire [31:0] WB_DAT_IN,
    output reg [31:0] WB_DAT_OUT,
    output reg WB_ACK_OUT,
    input wire ENC_A_IN,
    input wire ENC_B_IN,
    input wire ENC_IDX_IN,
    input wire TRIG_IN,
    input wire SHDN_IN,
    output reg CMP_OUT,
    output reg CMP_OE_N_OUT,
    output reg TRIG_BUS_OUT,
    output reg DRV_DISABLE_OUT,
    output reg SERVO_ZERO_OUT,
    output reg STEP_HALT_OUT,
    output reg IRQ_OUT
);

    // ************************************************************
    // input synchronisers and filters
    // ************************************************************
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    always @(posedge MCLK_IN) begin
        if (RST_IN) begin
            sync1_q <= 5'h1f;
            sync2_q <= 5'h1f;
        end else begin
            sync1_q <= {SHDN_IN, TRIG_IN, ENC_IDX_IN, ENC_B_IN, ENC_A_IN};
            sync2_q <= sync1_q;
        end
    end

    reg [31:0] filt_q;
    wire [FILT_W-1:0] filt_len = filt_q[FILT_W-1:0];
    wire [2:0] filt_out;

    // each of a, b, index must hold a new level filt_len+1 cycles
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
            reg [FILT_W-1:0] cnt_q;
            reg lvl_q;
            always @(posedge MCLK_IN) begin
                if (RST_IN) begin
                    cnt_q <= {FILT_W{1'b0}};
                    lvl_q <= 1'b1;
                end else if (sync2_q[gi] == lvl_q) begin
                    cnt_q <= {FILT_W{1'b0}};
                end else if (cnt_q >= filt_len) begin
                    cnt_q <= {FILT_W{1'b0}};
                    lvl_q <= sync2_q[gi];
                end else begin
                    cnt_q <= cnt_q + {{(FILT_W-1){1'b0}}, 1'b1};
                end
            end
            assign filt_out[gi] = lvl_q;
        end
    endgenerate

    // ************************************************************
    // quadrature counter
    // ************************************************************
    reg [1:0] ab_q;
    reg idx_q;
    reg [31:0] count_q;
    wire [1:0] ab = filt_out[1:0];
    // x4 decode: a leading b counts up, b leading a counts down
    wire step_up = (ab_q == 2'b00 && ab == 2'b01) || (ab_q == 2'b01 && ab == 2'b11) ||
                   (ab_q == 2'b11 && ab == 2'b10) || (ab_q == 2'b10 && ab == 2'b00);
    wire step_dn = (ab_q == 2'b00 && ab == 2'b10) || (ab_q == 2'b10 && ab == 2'b11) ||
                   (ab_q == 2'b11 && ab == 2'b01) || (ab_q == 2'b01 && ab == 2'b00);
    // index only flags an event; counting never needs it
    wire idx_rise = filt_out[2] & ~idx_q;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire bus_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    // writes land at the edge where the master samples ack high
    wire bus_wr = WB_CYC_IN & WB_STB_IN & WB_ACK_OUT & WB_WE_IN;
    wire bus_rd = bus_req & ~WB_WE_IN;
    wire [31:0] be = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}},
                      {8{WB_SEL_IN[0]}}};
    wire wr_ctrl = bus_wr && WB_ADR_IN == `ECC_REG_CTRL;
    wire wr_filt = bus_wr && WB_ADR_IN == `ECC_REG_FILT;
    wire wr_count = bus_wr && WB_ADR_IN == `ECC_REG_COUNT;
    wire wr_pos = bus_wr && WB_ADR_IN == `ECC_REG_CMPPOS;
    wire wr_per = bus_wr && WB_ADR_IN == `ECC_REG_CMPPER;
    wire wr_cfg = bus_wr && WB_ADR_IN == `ECC_REG_CMPCFG;
    wire wr_mask = bus_wr && WB_ADR_IN == `ECC_REG_MASK;
    wire wr_buf = bus_wr && WB_ADR_IN == `ECC_REG_BUFPOS;
    wire rd_status = bus_rd && WB_ADR_IN == `ECC_REG_STATUS;

    reg [31:0] ctrl_q;
    reg [31:0] cmppos_q;
    reg [31:0] cmpper_q;
    reg [31:0] cfg_q;
    reg [3:0] mask_q;
    reg [31:0] capt_q;
    reg [31:0] target_q;
    reg armed_q;
    reg [3:0] status_q;
    reg trig_prev_q;
    reg shd_prev_q;
    reg shd_q;
    reg [31:0] buf_mem [0:BUF_DEPTH-1];
    reg [BUF_AW:0] buf_cnt_q;
    reg [BUF_AW-1:0] buf_rd_q;
    reg [BUF_AW-1:0] buf_wr_q;
    reg [7:0] pulse_q;
    reg [7:0] trig_pulse_q;
    localparam [31:0] TRIG_CYC_W = `ECC_TRIG_CYC;
    wire [7:0] trig_cyc = TRIG_CYC_W[7:0];

    wire [31:0] ctrl_d = (ctrl_q & ~be) | (WB_DAT_IN & be);
    wire [31:0] cfg_d = (cfg_q & ~be) | (WB_DAT_IN & be);

    // ************************************************************
    // capture and shutdown
    // ************************************************************
    wire trig = sync2_q[3];
    wire [1:0] cap_sel = ctrl_q[`ECC_CTRL_CAP_HI:`ECC_CTRL_CAP_LO];
    reg cap_hit;
    always @* begin
        case (cap_sel)
            `ECC_CAP_LOW: cap_hit = ~trig;
            `ECC_CAP_HIGH: cap_hit = trig;
            `ECC_CAP_RISE: cap_hit = trig & ~trig_prev_q;
            `ECC_CAP_FALL: cap_hit = ~trig & trig_prev_q;
            default: cap_hit = 1'b0;
        endcase
    end
    wire cap_ev = ctrl_q[`ECC_CTRL_CAP_EN] & cap_hit;
    // edge only, a standing high level never trips it
    wire shd_ev = ctrl_q[`ECC_CTRL_SHD_EN] & sync2_q[4] & ~shd_prev_q;

    // ************************************************************
    // compare engine
    // ************************************************************
    wire [1:0] mode = cfg_q[`ECC_CFG_MODE_HI:`ECC_CFG_MODE_LO];
    wire [1:0] act = cfg_q[`ECC_CFG_ACT_HI:`ECC_CFG_ACT_LO];
    wire arm_wr = wr_cfg & WB_SEL_IN[0] & WB_DAT_IN[`ECC_CFG_ARM];
    wire cmp_hit = armed_q && count_q == target_q;
    wire buf_full = buf_cnt_q == BUF_DEPTH;
    wire buf_empty = buf_cnt_q == {(BUF_AW+1){1'b0}};
    wire buf_pop = cmp_hit && mode == `ECC_MODE_BUF && !buf_empty;
    wire buf_push = wr_buf && !buf_full;

    reg [31:0] arm_target;
    always @* begin
        case (WB_DAT_IN[`ECC_CFG_MODE_HI:`ECC_CFG_MODE_LO])
            `ECC_MODE_REL: arm_target = count_q + cmppos_q;
            `ECC_MODE_BUF: arm_target = buf_mem[buf_rd_q];
            default: arm_target = cmppos_q;
        endcase
    end

    // next compare level; the pin enable follows it at the same edge
    reg cmp_d;
    reg [7:0] pulse_d;
    always @* begin
        cmp_d = CMP_OUT;
        pulse_d = pulse_q;
        if (wr_cfg && WB_SEL_IN[1] && WB_DAT_IN[`ECC_CFG_FORCE]) begin
            cmp_d = WB_DAT_IN[`ECC_CFG_FORCE_LVL];
            pulse_d = 8'h00;
        end else if (wr_cfg && WB_SEL_IN[0] && WB_DAT_IN[`ECC_CFG_PRESET]) begin
            cmp_d = WB_DAT_IN[`ECC_CFG_PRE_LVL];
            pulse_d = 8'h00;
        end else if (cmp_hit) begin
            case (act)
                `ECC_ACT_SET: cmp_d = 1'b1;
                `ECC_ACT_CLR: cmp_d = 1'b0;
                `ECC_ACT_TOG: cmp_d = ~CMP_OUT;
                `ECC_ACT_PULSE: begin
                    cmp_d = ~cfg_q[`ECC_CFG_PRE_LVL];
                    pulse_d = trig_cyc;
                end
                default: cmp_d = CMP_OUT;
            endcase
        end else if (pulse_q == 8'h01) begin
            cmp_d = cfg_q[`ECC_CFG_PRE_LVL];
            pulse_d = 8'h00;
        end else if (pulse_q != 8'h00) begin
            pulse_d = pulse_q - 8'h01;
        end
    end
    wire oc_d = wr_cfg ? cfg_d[`ECC_CFG_OPEN_COL] : cfg_q[`ECC_CFG_OPEN_COL];

    always @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ab_q <= 2'b11;
            idx_q <= 1'b1;
            count_q <= 32'h0000_0000;
            ctrl_q <= 32'h0000_0000;
            filt_q <= `ECC_FILT_RST;
            cmppos_q <= 32'h0000_0000;
            cmpper_q <= 32'h0000_0000;
            cfg_q <= `ECC_CFG_RST;
            mask_q <= 4'h0;
            capt_q <= 32'h0000_0000;
            target_q <= 32'h0000_0000;
            armed_q <= 1'b0;
            status_q <= 4'h0;
            trig_prev_q <= 1'b1;
            shd_prev_q <= 1'b1;
            shd_q <= 1'b0;
            buf_cnt_q <= {(BUF_AW+1){1'b0}};
            buf_rd_q <= {BUF_AW{1'b0}};
            buf_wr_q <= {BUF_AW{1'b0}};
            pulse_q <= 8'h00;
            trig_pulse_q <= 8'h00;
            CMP_OUT <= 1'b0;
            CMP_OE_N_OUT <= 1'b0;
            TRIG_BUS_OUT <= 1'b0;
            DRV_DISABLE_OUT <= 1'b0;
            SERVO_ZERO_OUT <= 1'b0;
            STEP_HALT_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0000_0000;
        end else begin
            ab_q <= ab;
            idx_q <= filt_out[2];
            trig_prev_q <= trig;
            shd_prev_q <= sync2_q[4];
            if (wr_count) begin
                count_q <= (count_q & ~be) | (WB_DAT_IN & be);
            end else if (step_up) begin
                count_q <= count_q + 32'h0000_0001;
            end else if (step_dn) begin
                count_q <= count_q - 32'h0000_0001;
            end
            if (wr_ctrl) begin
                ctrl_q <= ctrl_d & ~(32'h1 << `ECC_CTRL_SHD_CLR);
            end
            if (wr_filt) begin
                filt_q <= (filt_q & ~be) | (WB_DAT_IN & be);
            end
            if (wr_pos) begin
                cmppos_q <= (cmppos_q & ~be) | (WB_DAT_IN & be);
            end
            if (wr_per) begin
                cmpper_q <= (cmpper_q & ~be) | (WB_DAT_IN & be);
            end
            if (wr_cfg) begin
                cfg_q <= cfg_d & ~(32'h1 << `ECC_CFG_ARM) & ~(32'h1 << `ECC_CFG_PRESET);
            end
            if (wr_mask && WB_SEL_IN[0]) begin
                mask_q <= WB_DAT_IN[`ECC_ST_W-1:0];
            end
            // capture latches the live count; status alone serves as latched input
            if (cap_ev) begin
                capt_q <= count_q;
            end
            // buffered positions queue
            if (buf_push) begin
                buf_mem[buf_wr_q] <= WB_DAT_IN;
                buf_wr_q <= buf_wr_q + {{(BUF_AW-1){1'b0}}, 1'b1};
            end
            if (buf_pop) begin
                buf_rd_q <= buf_rd_q + {{(BUF_AW-1){1'b0}}, 1'b1};
            end
            if (buf_push && !buf_pop) begin
                buf_cnt_q <= buf_cnt_q + {{BUF_AW{1'b0}}, 1'b1};
            end else if (buf_pop && !buf_push) begin
                buf_cnt_q <= buf_cnt_q - {{BUF_AW{1'b0}}, 1'b1};
            end
            // arming and re-arming
            if (arm_wr) begin
                target_q <= arm_target;
                armed_q <= 1'b1;
            end else if (cmp_hit) begin
                if (mode == `ECC_MODE_PER) begin
                    target_q <= target_q + cmpper_q;
                end else if (mode == `ECC_MODE_BUF && buf_cnt_q > 1) begin
                    target_q <= buf_mem[buf_rd_q + {{(BUF_AW-1){1'b0}}, 1'b1}];
                end else begin
                    armed_q <= 1'b0;
                end
            end
            // compare output level
            CMP_OUT <= cmp_d;
            pulse_q <= pulse_d;
            // open-collector drives only low; enable low while driving
            CMP_OE_N_OUT <= oc_d & cmp_d;
            if (cmp_hit && cfg_q[`ECC_CFG_TRIG_EN]) begin
                trig_pulse_q <= trig_cyc;
                TRIG_BUS_OUT <= 1'b1;
            end else if (trig_pulse_q > 8'h01) begin
                trig_pulse_q <= trig_pulse_q - 8'h01;
            end else begin
                trig_pulse_q <= 8'h00;
                TRIG_BUS_OUT <= 1'b0;
            end
            // shutdown holds until software clears it
            if (shd_ev) begin
                shd_q <= 1'b1;
            end else if (wr_ctrl && WB_SEL_IN[0] && WB_DAT_IN[`ECC_CTRL_SHD_CLR]) begin
                shd_q <= 1'b0;
            end
            DRV_DISABLE_OUT <= shd_q | shd_ev;
            SERVO_ZERO_OUT <= shd_q | shd_ev;
            STEP_HALT_OUT <= shd_q | shd_ev;
            // sticky status: set wins over read clear
            status_q <= (rd_status ? 4'h0 : status_q) |
                        {idx_rise, shd_ev, cmp_hit, cap_ev};
            IRQ_OUT <= |(status_q & mask_q);
            // classic wishbone: ack one cycle after the strobe
            WB_ACK_OUT <= bus_req;
            if (bus_rd) begin
                case (WB_ADR_IN)
                    `ECC_REG_CTRL: WB_DAT_OUT <= ctrl_q;
                    `ECC_REG_FILT: WB_DAT_OUT <= filt_q;
                    `ECC_REG_COUNT: WB_DAT_OUT <= count_q;
                    `ECC_REG_CAPT: WB_DAT_OUT <= capt_q;
                    `ECC_REG_CMPPOS: WB_DAT_OUT <= cmppos_q;
                    `ECC_REG_CMPPER: WB_DAT_OUT <= cmpper_q;
                    `ECC_REG_CMPCFG: WB_DAT_OUT <= {cfg_q[31:1], armed_q};
                    `ECC_REG_STATUS: WB_DAT_OUT <= {27'h0, shd_q, status_q};
                    `ECC_REG_MASK: WB_DAT_OUT <= {28'h0, mask_q};
                    `ECC_REG_PINS: WB_DAT_OUT <= {26'h0, CMP_OUT, sync2_q[4:3], filt_out};
                    `ECC_REG_BUFPOS: WB_DAT_OUT <= {{(32-BUF_AW-1){1'b0}}, buf_cnt_q};
                    default: WB_DAT_OUT <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// file: src/ecc_defs.vh
/*
 * constants for the encoder capture/compare block: register offsets,
 * field positions, reset values, mode codes and timing counts.
 * assumes inclusion by bare name from the design file and both bench files that use it.
 */
`ifndef ECC_DEFS_VH
`define ECC_DEFS_VH

// register byte offsets (one 32-bit word each)
`define ECC_REG_CTRL      6'h00
`define ECC_REG_FILT      6'h04
`define ECC_REG_COUNT     6'h08
`define ECC_REG_CAPT      6'h0c
`define ECC_REG_CMPPOS    6'h10
`define ECC_REG_CMPPER    6'h14
`define ECC_REG_CMPCFG    6'h18
`define ECC_REG_STATUS    6'h1c
`define ECC_REG_MASK      6'h20
`define ECC_REG_PINS      6'h24
`define ECC_REG_BUFPOS    6'h28
`define ECC_ADDR_W        6

// ctrl fields
`define ECC_CTRL_CAP_EN   0
`define ECC_CTRL_SHD_EN   1
`define ECC_CTRL_CAP_LO   2
`define ECC_CTRL_CAP_HI   3
`define ECC_CTRL_SHD_CLR  4
`define ECC_CTRL_IDX_CLR  5

// compare config fields
`define ECC_CFG_MODE_LO   0
`define ECC_CFG_MODE_HI   1
`define ECC_CFG_ACT_LO    2
`define ECC_CFG_ACT_HI    3
`define ECC_CFG_ARM       4
`define ECC_CFG_PRESET    5
`define ECC_CFG_PRE_LVL   6
`define ECC_CFG_OPEN_COL  7
`define ECC_CFG_FORCE     8
`define ECC_CFG_FORCE_LVL 9
`define ECC_CFG_TRIG_EN   10

// status bits
`define ECC_ST_CAPT       0
`define ECC_ST_CMP        1
`define ECC_ST_SHD        2
`define ECC_ST_INDEX      3
`define ECC_ST_W          4

// capture conditions
`define ECC_CAP_LOW       2'h0
`define ECC_CAP_HIGH      2'h1
`define ECC_CAP_RISE      2'h2
`define ECC_CAP_FALL      2'h3

// compare position modes
`define ECC_MODE_ABS      2'h0
`define ECC_MODE_REL      2'h1
`define ECC_MODE_PER      2'h2
`define ECC_MODE_BUF      2'h3

// compare output actions
`define ECC_ACT_SET       2'h0
`define ECC_ACT_CLR       2'h1
`define ECC_ACT_TOG       2'h2
`define ECC_ACT_PULSE     2'h3

// reset values
`define ECC_FILT_RST      32'h0000_0003
`define ECC_CFG_RST       32'h0000_0000

// timing
`define ECC_CLK_NS        8
`define ECC_TRIG_PULSE_NS 200
`define ECC_TRIG_CYC      ((`ECC_TRIG_PULSE_NS + `ECC_CLK_NS - 1) / `ECC_CLK_NS)

`endif

// file: tb/ecc_capture_compare_props.sv
/* port checker for the capture/compare block.
   bound to every ecc_capture_compare instance; one clock, sync reset. */
`timescale 1ns/1ps
`include "ecc_defs.vh"
module ecc_capture_compare_props (
    input wire MCLK_IN,
    input wire RST_IN,
    input wire WB_WE_IN,
    input wire [`ECC_ADDR_W-1:0] WB_ADR_IN,
    input wire [31:0] WB_DAT_OUT,
    input wire WB_ACK_OUT,
    input wire SHDN_IN,
    input wire CMP_OUT,
    input wire CMP_OE_N_OUT,
    input wire TRIG_BUS_OUT,
    input wire DRV_DISABLE_OUT,
    input wire SERVO_ZERO_OUT,
    input wire STEP_HALT_OUT,
    input wire IRQ_OUT
);
    // ****
    // pulse length and time since shutdown pin was low
    // ****
    reg [7:0] trig_len_q;
    reg [3:0] low_ago_q;
    always @(posedge MCLK_IN) begin
        if (RST_IN) begin
            trig_len_q <= 8'h00;
            low_ago_q <= 4'hf;
        end else begin
            trig_len_q <= TRIG_BUS_OUT ? trig_len_q + 8'h01 : 8'h00;
            if (!SHDN_IN)
                low_ago_q <= 4'h0;
            else if (low_ago_q != 4'hf)
                low_ago_q <= low_ago_q + 4'h1;
        end
    end
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack stood longer than one cycle");
    a_unmapped_zero: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN > `ECC_REG_BUFPOS
        |-> WB_DAT_OUT == 32'h0) else $error("unmapped read not zero");
    a_shd_outputs_same: assert property (DRV_DISABLE_OUT == SERVO_ZERO_OUT &&
        DRV_DISABLE_OUT == STEP_HALT_OUT) else $error("shutdown outputs disagree");
    a_shd_edge_only: assert property ($rose(DRV_DISABLE_OUT) |-> low_ago_q < 4'h8)
        else $error("shutdown without a rising pin");
    a_trig_pulse_len: assert property ($fell(TRIG_BUS_OUT) |-> trig_len_q == `ECC_TRIG_CYC)
        else $error("trigger pulse too short");
    a_trig_not_long: assert property (TRIG_BUS_OUT |-> trig_len_q < `ECC_TRIG_CYC)
        else $error("trigger pulse too long");
    a_oe_sink_high: assert property (CMP_OE_N_OUT |-> CMP_OUT)
        else $error("pin released while driving low");
    a_reset_quiet: assert property ($fell(RST_IN) |-> !CMP_OUT && !CMP_OE_N_OUT &&
        !TRIG_BUS_OUT && !DRV_DISABLE_OUT && !IRQ_OUT) else $error("outputs not idle at reset");
endmodule
bind ecc_capture_compare ecc_capture_compare_props u_ecc_capture_compare_props (
    .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
    .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .SHDN_IN(SHDN_IN), .CMP_OUT(CMP_OUT),
    .CMP_OE_N_OUT(CMP_OE_N_OUT), .TRIG_BUS_OUT(TRIG_BUS_OUT), .DRV_DISABLE_OUT(DRV_DISABLE_OUT),
    .SERVO_ZERO_OUT(SERVO_ZERO_OUT), .STEP_HALT_OUT(STEP_HALT_OUT), .IRQ_OUT(IRQ_OUT));

// file: tb/ecc_capture_compare_test.sv
/* self-checking bench for the capture/compare block.
   drives wishbone, trigger and shutdown pins; the encoder model moves the count. */
`timescale 1ns/1ps
`include "ecc_defs.vh"
module ecc_capture_compare_test;
    localparam logic [3:0] PL = 4'h2, E1 = 4'h5, E2 = 4'h1, ARMD = 4'h4;
    logic mclk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, trig = 1'b1, shdn = 1'b1;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    logic signed [31:0] tgt = 32'sh2;
    logic [7:0] gap = 8'h03;
    wire [31:0] rdat;
    wire ack, enc_a, enc_b, enc_i, done, cmp, oe_n, tbus, drv, servo, step, irq;
    logic [31:0] exp_q[$], msk_q[$];
    int n_errors = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    ecc_enc_model u_ecc_enc_model (.clk_in(mclk), .rst_in(rst), .target_in(tgt), .gap_in(gap),
        .a_out(enc_a), .b_out(enc_b), .idx_out(enc_i), .done_out(done));
    ecc_capture_compare u_ecc_capture_compare (.MCLK_IN(mclk), .RST_IN(rst), .WB_CYC_IN(req),
        .WB_STB_IN(req), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .ENC_A_IN(enc_a), .ENC_B_IN(enc_b),
        .ENC_IDX_IN(enc_i), .TRIG_IN(trig), .SHDN_IN(shdn), .CMP_OUT(cmp), .CMP_OE_N_OUT(oe_n),
        .TRIG_BUS_OUT(tbus), .DRV_DISABLE_OUT(drv), .SERVO_ZERO_OUT(servo),
        .STEP_HALT_OUT(step), .IRQ_OUT(irq));
    // ****
    // shared tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one classic cycle; a read leaves its expected value for the monitor
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
        input logic [31:0] m);
        if (!w) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= w ? d : 32'h0;
        do @(posedge mclk); while (ack !== 1'b1);
        req <= 1'b0;
    endtask
    task automatic mv(input int d, input logic [7:0] g);
        @(posedge mclk);
        tgt <= tgt + d;
        gap <= g;
        @(posedge mclk);
        while (done !== 1'b1) @(posedge mclk);
        wt(12);
    endtask
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0)
                n_errors++;
            else
                check(rdat & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        #(8 * 20000);
        n_errors++;
        print_verdict;
    end
    // ****
    // scenarios
    // ****
    initial begin : main
        int d, c;
        logic [31:0] v, base;
        logic idle;
        void'($urandom(32'h5190));
        wt(10);
        rst <= 1'b0;
        wt(1);
        check({31'h0, oe_n}, 32'h0);
        bus(1'b0, `ECC_REG_FILT, `ECC_FILT_RST, 32'hffff_ffff);
        bus(1'b0, `ECC_REG_CMPCFG, `ECC_CFG_RST, 32'hffff_ffff);
        bus(1'b0, 6'h3c, 32'h0, 32'hffff_ffff);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `ECC_REG_FILT, k ? 32'h5 : 32'h0, 32'h0);
            bus(1'b1, `ECC_REG_COUNT, 32'h0, 32'h0);
            d = int'($urandom % 41) - 20;
            mv(d, k ? 8'h0c : 8'h03);
            bus(1'b0, `ECC_REG_COUNT, d, 32'hffff_ffff);
        end
        // capture per condition; irq unmasked only on high and fall
        for (c = 0; c < 4; c++) begin
            idle = (c == 0 || c == 3);
            v = $urandom;
            trig <= idle;
            bus(1'b1, `ECC_REG_COUNT, v, 32'h0);
            bus(1'b1, `ECC_REG_MASK, c & 1, 32'h0);
            bus(1'b1, `ECC_REG_CTRL, 32'h1 | (c << 2), 32'h0);
            bus(1'b0, `ECC_REG_STATUS, 32'h0, 32'h0);
            bus(1'b0, `ECC_REG_STATUS, 32'h0, 32'h1);
            trig <= !idle;
            wt(6);
            check({31'h0, irq}, c & 1);
            bus(1'b0, `ECC_REG_CAPT, v, 32'hffff_ffff);
            trig <= idle;
            wt(4);
            bus(1'b0, `ECC_REG_STATUS, 32'h1, 32'h1);
            wt(3);
            check({31'h0, irq}, 32'h0);
        end
        // steady high level first, then a real rising edge
        bus(1'b1, `ECC_REG_CTRL, 32'h2, 32'h0);
        wt(8);
        check({31'h0, drv}, 32'h0);
        shdn <= 1'b0;
        wt(6);
        shdn <= 1'b1;
        wt(6);
        check({29'h0, drv, servo, step}, 32'h7);
        bus(1'b0, `ECC_REG_STATUS, 32'h4, 32'h4);
        bus(1'b1, `ECC_REG_CTRL, 32'h12, 32'h0);
        wt(3);
        check({29'h0, drv, servo, step}, 32'h0);
        // sixteen counts always cross one index pulse
        mv(16, 8'h0a);
        bus(1'b0, `ECC_REG_STATUS, 32'h8, 32'h8);
        // pass c pairs position mode c with output action c
        for (c = 0; c < 4; c++) begin
            base = $urandom & 32'h0fff_fff0;
            bus(1'b1, `ECC_REG_COUNT, base, 32'h0);
            bus(1'b1, `ECC_REG_CMPPER, 32'h4, 32'h0);
            bus(1'b1, `ECC_REG_CMPPOS, (c == 1) ? 32'h6 : base + 32'h6, 32'h0);
            if (c == 3) begin
                bus(1'b1, `ECC_REG_BUFPOS, base + 32'h6, 32'h0);
                bus(1'b1, `ECC_REG_BUFPOS, base + 32'ha, 32'h0);
                bus(1'b0, `ECC_REG_BUFPOS, 32'h2, 32'h7);
            end
            bus(1'b1, `ECC_REG_CMPCFG, 32'h20 | (PL[c] << `ECC_CFG_PRE_LVL), 32'h0);
            wt(2);
            check({31'h0, cmp}, PL[c]);
            bus(1'b1, `ECC_REG_CMPCFG, 32'h410 | (c << 2) | c, 32'h0);
            mv(6, 8'h0a);
            wt(30);
            check({31'h0, cmp}, E1[c]);
            mv(4, 8'h0a);
            wt(30);
            check({31'h0, cmp}, E2[c]);
            bus(1'b0, `ECC_REG_CMPCFG, ARMD[c], 32'h1);
        end
        // forced level with the sink-only driver
        bus(1'b1, `ECC_REG_CMPCFG, 32'h380, 32'h0);
        wt(2);
        check({30'h0, cmp, oe_n}, 32'h3);
        bus(1'b1, `ECC_REG_CMPCFG, 32'h180, 32'h0);
        wt(2);
        check({30'h0, cmp, oe_n}, 32'h0);
        print_verdict;
    end
endmodule

// file: tb/ecc_enc_model.sv
/* quadrature encoder model: steps toward target_in, one count per gap_in+1 cycles.
   assumes the bench changes target only while done_out is high. */
`timescale 1ns/1ps
module ecc_enc_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic signed [31:0] target_in,
    input wire logic [7:0] gap_in,
    output logic a_out,
    output logic b_out,
    output logic idx_out,
    output logic done_out
);
    logic signed [31:0] pos_q;
    logic [7:0] wait_q;
    // rests with both phases high, the pull-up level
    always @(posedge clk_in) begin
        if (rst_in) begin
            pos_q <= 32'sh2;
            wait_q <= 8'h00;
        end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end else if (pos_q != target_in) begin
            pos_q <= (target_in > pos_q) ? pos_q + 32'sh1 : pos_q - 32'sh1;
            wait_q <= gap_in;
        end
    end
    assign a_out = pos_q[1] ^ pos_q[0];
    assign b_out = pos_q[1];
    assign idx_out = (pos_q[3:0] == 4'h0);
    assign done_out = (pos_q == target_in) && (wait_q == 8'h00);
endmodule
